// [verilog/dtfs_pkg.sv]
`default_nettype none
// ---------------------------------------------------------------
// shared constants for the tone frame substitution block
// ---------------------------------------------------------------
package dtfs_pkg;
   // register offsets on the internal register port
   localparam logic [7:0] ADDR_CODER_CFG = 8'h07;
   localparam logic [7:0] ADDR_TONE_SEND = 8'h08;
   localparam logic [7:0] ADDR_CODER_CTRL = 8'h11;
   localparam logic [7:0] ADDR_RX_CODE = 8'h37;
   // field positions
   localparam int CFG_FMT_BIT = 7; // code format select
   localparam int CTRL_RX_EN_BIT = 5; // tone reception enable
   localparam int CTRL_REGEN_BIT = 6; // regenerate tone, else silence
   localparam int CTRL_AUTO_BIT = 11; // auto tone detect enable
   localparam int SEND_CODE_LSB = 0; // host code, bits 3:0
   localparam int SEND_CNT_LSB = 4; // frame count, bits 7:4
   // field values
   localparam logic [3:0] SEND_CNT_OFF = 4'h0; // direct sending off
   localparam logic [3:0] SEND_CNT_CONT = 4'hF; // continuous sending
   localparam logic [3:0] SEND_CNT_ONE = 4'h1; // decrement step
   // values after reset
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] SEND_RST = 8'h00;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [3:0] RX_CODE_RST = 4'h0;
   // frame sizes
   localparam int FRAME_W = 56; // coded voice frame bits
   localparam int FIFO_DEPTH = 8; // outgoing frame buffer depth
   // outgoing frame kind
   typedef enum logic [0:0] {
      FRM_VOICE = 1'b0,
      FRM_TONE = 1'b1
   } dtfs_frame_t;
   // audio output state of the decode side
   typedef enum logic [1:0] {
      AUD_VOICE = 2'b00,
      AUD_TONE = 2'b01,
      AUD_SILENCE = 2'b10
   } dtfs_audio_t;
endpackage
`default_nettype wire

// [verilog/dtfs_fifo.sv]
`default_nettype none
// ---------------------------------------------------------------
// small flop based fifo with valid/ready on both sides
// ---------------------------------------------------------------
module dtfs_fifo #(
   parameter int WIDTH = 57,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH); // fill level that means full

   logic [WIDTH-1:0] mem_r [DEPTH]; // storage words
   logic [AW-1:0] wr_ptr_r; // write index
   logic [AW-1:0] rd_ptr_r; // read index
   logic [AW:0] count_r; // words held
   logic push; // word accepted
   logic pop; // word delivered

   assign in_ready = (count_r != DEPTH_C);
   assign out_valid = (count_r != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_r[rd_ptr_r];

   // write side
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk) begin
      if (srst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         case ({push, pop})
            2'b10: count_r <= count_r + 1'b1;
            2'b01: count_r <= count_r - 1'b1;
            default: count_r <= count_r;
         endcase
      end
   end
endmodule // dtfs_fifo
`default_nettype wire

// [verilog/dtfs_top.sv]
`default_nettype none
// What this block does
// - tone frames only in half duplex operation
// - encoder may replace voice frames with tone frames
// - auto bit sends detected tones as tone frames
// - direct mode carries host code bits 3:0
// - bits 7:4 count frames; 0 off, F continuous
// - direct host code wins over auto detection
// - decoder recognises incoming tone frames when enabled
// - bits 5,6 set: store code, regenerate tone
// - bit 5 only: store code, output silence
// - config bit 7 selects code format
// - first format maps D,1-9,0,star,hash,A-C
// - keypad format: row bits 3:2, column 1:0
module dtfs_top
   import dtfs_pkg::*;
#(
   parameter int FRAME_BITS = FRAME_W,
   parameter int BUF_DEPTH = FIFO_DEPTH
) (
   input wire logic CORE_CLK,
   input wire logic SRST,
   input wire logic HALF_DUPLEX,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   output logic [15:0] REG_RDATA,
   output logic REG_RVALID,
   input wire logic TONE_DET,
   input wire logic [1:0] TONE_ROW,
   input wire logic [1:0] TONE_COL,
   input wire logic VOICE_VALID,
   output logic VOICE_READY,
   input wire logic [FRAME_BITS-1:0] VOICE_DATA,
   output logic ENC_VALID,
   input wire logic ENC_READY,
   output logic ENC_IS_TONE,
   output logic [FRAME_BITS-1:0] ENC_DATA,
   input wire logic DEC_VALID,
   input wire logic DEC_IS_TONE,
   input wire logic [FRAME_BITS-1:0] DEC_DATA,
   output logic DEC_VOICE_VALID,
   output logic [FRAME_BITS-1:0] DEC_VOICE_DATA,
   output logic TONE_GEN_EN,
   output logic [1:0] TONE_GEN_ROW,
   output logic [1:0] TONE_GEN_COL,
   output logic AUDIO_SILENCE
);
   // ---------------------------------------------------------------
   // code format conversion
   // ---------------------------------------------------------------
   // keypad position (row,col) to code in the selected format
   function automatic logic [3:0] key_to_code(input logic fmt_keypad, input logic [3:0] key);
      logic [3:0] c;
      c = 4'h0;
      if (fmt_keypad) begin
         c = key;
      end else begin
         case (key)
            4'h0: c = 4'h1; // 1
            4'h1: c = 4'h2; // 2
            4'h2: c = 4'h3; // 3
            4'h3: c = 4'hD; // A
            4'h4: c = 4'h4; // 4
            4'h5: c = 4'h5; // 5
            4'h6: c = 4'h6; // 6
            4'h7: c = 4'hE; // B
            4'h8: c = 4'h7; // 7
            4'h9: c = 4'h8; // 8
            4'hA: c = 4'h9; // 9
            4'hB: c = 4'hF; // C
            4'hC: c = 4'hB; // star
            4'hD: c = 4'hA; // 0
            4'hE: c = 4'hC; // hash
            default: c = 4'h0; // D
         endcase
      end
      return c;
   endfunction

   // code in the selected format to keypad position (row,col)
   function automatic logic [3:0] code_to_key(input logic fmt_keypad, input logic [3:0] code);
      logic [3:0] k;
      k = 4'h0;
      if (fmt_keypad) begin
         k = code;
      end else begin
         case (code)
            4'h0: k = 4'hF; // D
            4'h1: k = 4'h0; // 1
            4'h2: k = 4'h1; // 2
            4'h3: k = 4'h2; // 3
            4'h4: k = 4'h4; // 4
            4'h5: k = 4'h5; // 5
            4'h6: k = 4'h6; // 6
            4'h7: k = 4'h8; // 7
            4'h8: k = 4'h9; // 8
            4'h9: k = 4'hA; // 9
            4'hA: k = 4'hD; // 0
            4'hB: k = 4'hC; // star
            4'hC: k = 4'hE; // hash
            4'hD: k = 4'h3; // A
            4'hE: k = 4'h7; // B
            default: k = 4'hB; // C
         endcase
      end
      return k;
   endfunction

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic [7:0] cfg_r; // coder_configuration
   logic [7:0] send_r; // tone_send_control, count field counts down
   logic [15:0] ctrl_r; // coder_control
   logic [3:0] rx_code_r; // received_tone_code
   logic [15:0] rdata_r; // read data word
   logic rvalid_r; // read answer strobe
   logic wr_send; // host write to tone_send_control
   logic [3:0] send_cnt; // remaining direct frames
   logic [3:0] send_code; // host supplied code
   logic fmt_keypad; // keypad row/column format selected

   assign wr_send = REG_WR && (REG_ADDR == ADDR_TONE_SEND);
   assign send_cnt = send_r[SEND_CNT_LSB +: 4];
   assign send_code = send_r[SEND_CODE_LSB +: 4];
   assign fmt_keypad = cfg_r[CFG_FMT_BIT];

   // configuration and control writes
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         cfg_r <= CFG_RST;
         ctrl_r <= CTRL_RST;
      end else if (REG_WR) begin
         if (REG_ADDR == ADDR_CODER_CFG) begin
            cfg_r <= REG_WDATA[7:0];
         end
         if (REG_ADDR == ADDR_CODER_CTRL) begin
            ctrl_r <= REG_WDATA;
         end
      end
   end

   // read port, only the received code is readable
   // every strobe is answered, so the host never waits on an unmapped offset
   // write only registers read back as zero, they hold no readable state
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         rdata_r <= 16'h0000;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= REG_RD;
         if (REG_RD) begin
            // unmapped or write only offsets read zero
            rdata_r <= (REG_ADDR == ADDR_RX_CODE) ? {12'h000, rx_code_r} : 16'h0000;
         end
      end
   end

   assign REG_RDATA = rdata_r;
   assign REG_RVALID = rvalid_r;

   // ---------------------------------------------------------------
   // encode side: frame substitution
   // ---------------------------------------------------------------
   logic tone_ok; // tone facility allowed
   logic frame_slot; // one outgoing frame taken this cycle
   logic direct_on; // direct sending active
   logic auto_on; // auto detected tone present
   logic fifo_in_ready; // buffer can take a frame
   logic [FRAME_BITS:0] enc_word; // {kind, frame} into buffer
   logic [FRAME_BITS:0] fifo_out; // {kind, frame} out of buffer
   dtfs_frame_t enc_kind; // kind of the frame being built
   logic [3:0] enc_code; // code carried by a tone frame

   assign tone_ok = HALF_DUPLEX;
   assign VOICE_READY = fifo_in_ready;
   assign frame_slot = VOICE_VALID && fifo_in_ready;
   assign direct_on = tone_ok && (send_cnt != SEND_CNT_OFF);
   assign auto_on = tone_ok && ctrl_r[CTRL_AUTO_BIT] && TONE_DET;

   // pick frame kind and code, direct mode first
   // kind is fixed in the taking cycle, a later host write
   // never alters a frame already waiting in the buffer
   always_comb begin
      enc_kind = FRM_VOICE;
      enc_code = 4'h0;
      if (direct_on) begin
         enc_kind = FRM_TONE;
         enc_code = send_code;
      end else if (auto_on) begin
         enc_kind = FRM_TONE;
         enc_code = key_to_code(fmt_keypad, {TONE_ROW, TONE_COL});
      end
   end

   // tone frame replaces the voice frame in its slot
   always_comb begin
      if (enc_kind == FRM_TONE) begin
         enc_word = {1'b1, {(FRAME_BITS-4){1'b0}}, enc_code};
      end else begin
         enc_word = {1'b0, VOICE_DATA};
      end
   end

   // direct frame counter, host write reloads it
   // host write wins over the decrement so a reload is never lost
   // a count of F never decrements, giving continuous tone frames
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         send_r <= SEND_RST;
      end else if (wr_send) begin
         send_r <= REG_WDATA[7:0];
      end else if (frame_slot && direct_on && (send_cnt != SEND_CNT_CONT)) begin
         send_r[SEND_CNT_LSB +: 4] <= send_cnt - SEND_CNT_ONE;
      end
   end

   // outgoing frame buffer
   // the sink may stall, the buffer holds up to BUF_DEPTH frames, then VOICE_READY drops and the coder is held
   dtfs_fifo #(
      .WIDTH(FRAME_BITS + 1),
      .DEPTH(BUF_DEPTH)
   ) u_fifo (
      .clk(CORE_CLK),
      .srst(SRST),
      .in_valid(VOICE_VALID),
      .in_ready(fifo_in_ready),
      .in_data(enc_word),
      .out_valid(ENC_VALID),
      .out_ready(ENC_READY),
      .out_data(fifo_out)
   );

   assign ENC_IS_TONE = fifo_out[FRAME_BITS];
   assign ENC_DATA = fifo_out[FRAME_BITS-1:0];

   // ---------------------------------------------------------------
   // decode side: tone frame handling
   // ---------------------------------------------------------------
   logic rx_tone; // received tone frame to be handled
   logic [3:0] rx_key; // keypad position of received code
   dtfs_audio_t aud_r; // current audio output state
   logic [3:0] gen_key_r; // regenerated tone position
   logic dv_valid_r; // decoded voice frame strobe
   logic [FRAME_BITS-1:0] dv_data_r; // decoded voice frame

   assign rx_tone = DEC_VALID && DEC_IS_TONE && tone_ok && ctrl_r[CTRL_RX_EN_BIT];
   assign rx_key = code_to_key(fmt_keypad, DEC_DATA[3:0]);

   // received code holds until the next handled tone frame
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         rx_code_r <= RX_CODE_RST;
      end else if (rx_tone) begin
         rx_code_r <= DEC_DATA[3:0];
      end
   end

   // audio state follows each received frame
   // a tone frame refused by duplex mode or enable is treated as voice
   // and clears any tone or silence left by an earlier frame
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         aud_r <= AUD_VOICE;
         gen_key_r <= 4'h0;
      end else if (DEC_VALID) begin
         case ({rx_tone, ctrl_r[CTRL_REGEN_BIT]})
            2'b11: begin
               aud_r <= AUD_TONE;
               gen_key_r <= rx_key;
            end
            2'b10: begin
               aud_r <= AUD_SILENCE;
            end
            default: begin
               aud_r <= AUD_VOICE;
            end
         endcase
      end
   end

   // voice frames pass on to the speech decoder
   // handled tone frames are swallowed here, never passed as speech
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         dv_valid_r <= 1'b0;
         dv_data_r <= '0;
      end else begin
         dv_valid_r <= DEC_VALID && !rx_tone;
         if (DEC_VALID && !rx_tone) begin
            dv_data_r <= DEC_DATA;
         end
      end
   end

   assign DEC_VOICE_VALID = dv_valid_r;
   assign DEC_VOICE_DATA = dv_data_r;
   assign TONE_GEN_EN = (aud_r == AUD_TONE);
   assign TONE_GEN_ROW = gen_key_r[3:2];
   assign TONE_GEN_COL = gen_key_r[1:0];
   assign AUDIO_SILENCE = (aud_r == AUD_SILENCE);
endmodule // dtfs_top
`default_nettype wire

// [tb/dtfs_chk.sv]
`default_nettype none
// ---------------------------------------------
// port checker for the tone frame block
// ---------------------------------------------
module dtfs_chk
   import dtfs_pkg::*;
#(
   parameter int FRAME_BITS = FRAME_W
) (
   input wire logic CORE_CLK,
   input wire logic SRST,
   input wire logic HALF_DUPLEX,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic [15:0] REG_RDATA,
   input wire logic REG_RVALID,
   input wire logic VOICE_VALID,
   input wire logic VOICE_READY,
   input wire logic ENC_VALID,
   input wire logic ENC_READY,
   input wire logic ENC_IS_TONE,
   input wire logic [FRAME_BITS-1:0] ENC_DATA,
   input wire logic DEC_VALID,
   input wire logic DEC_IS_TONE,
   input wire logic [FRAME_BITS-1:0] DEC_DATA,
   input wire logic DEC_VOICE_VALID,
   input wire logic TONE_GEN_EN,
   input wire logic [1:0] TONE_GEN_ROW,
   input wire logic [1:0] TONE_GEN_COL,
   input wire logic AUDIO_SILENCE
);
   timeunit 1ns;
   timeprecision 1ps;
   // first format code to row/col, one nibble per code
   localparam logic [63:0] POS_MAP = 64'hB73ECDA98654210F;
   logic [15:0] ctrl_r; // shadow of coder control
   logic fmt_r; // shadow of format bit
   logic [3:0] code_r; // code of the last offered frame
   logic hit; // tone frame that gets handled
   // shadows follow host writes
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         ctrl_r <= CTRL_RST;
         fmt_r <= 1'b0;
      end else if (REG_WR && REG_ADDR == ADDR_CODER_CTRL) begin
         ctrl_r <= REG_WDATA;
      end else if (REG_WR && REG_ADDR == ADDR_CODER_CFG) begin
         fmt_r <= REG_WDATA[CFG_FMT_BIT];
      end
   end
   // last frame code
   always_ff @(posedge CORE_CLK) begin
      code_r <= DEC_DATA[3:0];
   end
   assign hit = DEC_VALID && DEC_IS_TONE && HALF_DUPLEX && ctrl_r[CTRL_RX_EN_BIT];
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SRST);
   property p_rd;
      REG_RD && REG_ADDR == ADDR_RX_CODE |=> REG_RVALID && REG_RDATA[15:4] == 12'h000;
   endproperty
   a_rd: assert property (p_rd) else $error("code read bad");
   property p_dup;
      DEC_VALID && !HALF_DUPLEX |=> DEC_VOICE_VALID && !TONE_GEN_EN && !AUDIO_SILENCE;
   endproperty
   a_dup: assert property (p_dup) else $error("tone handled in full duplex");
   property p_regen;
      hit && ctrl_r[CTRL_REGEN_BIT] |=> TONE_GEN_EN && !AUDIO_SILENCE && !DEC_VOICE_VALID;
   endproperty
   a_regen: assert property (p_regen) else $error("no regeneration");
   property p_sil;
      hit && !ctrl_r[CTRL_REGEN_BIT] |=> AUDIO_SILENCE && !TONE_GEN_EN && !DEC_VOICE_VALID;
   endproperty
   a_sil: assert property (p_sil) else $error("no silence");
   property p_voice;
      DEC_VALID && !DEC_IS_TONE |=> DEC_VOICE_VALID && !TONE_GEN_EN && !AUDIO_SILENCE;
   endproperty
   a_voice: assert property (p_voice) else $error("voice frame mishandled");
   property p_key;
      hit && ctrl_r[CTRL_REGEN_BIT] && fmt_r |=> {TONE_GEN_ROW, TONE_GEN_COL} == code_r;
   endproperty
   a_key: assert property (p_key) else $error("keypad position bad");
   property p_fmt1;
      hit && ctrl_r[CTRL_REGEN_BIT] && !fmt_r |=> {TONE_GEN_ROW, TONE_GEN_COL} == POS_MAP[{code_r, 2'b00} +: 4];
   endproperty
   a_fmt1: assert property (p_fmt1) else $error("first format position bad");
   property p_hold;
      ENC_VALID && !ENC_READY |=> ENC_VALID && $stable(ENC_DATA) && $stable(ENC_IS_TONE);
   endproperty
   a_hold: assert property (p_hold) else $error("output frame moved");
   property p_first;
      VOICE_VALID && VOICE_READY && !ENC_VALID |=> ENC_VALID;
   endproperty
   a_first: assert property (p_first) else $error("frame not offered");
endmodule // dtfs_chk
`default_nettype wire

// [tb/dtfs_host.sv]
`default_nettype none
// ---------------------------------------------
// host model on the register port
// ---------------------------------------------
module dtfs_host (
   input wire logic clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
   end
   // one write, taken on a single edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_wdata = ~d; // released data does not stand
   endtask
   // one read, answer awaited a bounded number of edges
   task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
      ok = 1'b0;
      d = 16'h0000;
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      // answer stands for one cycle after the taking edge, look while settled
      for (int i = 0; i < 4 && !ok; i++) begin
         if (reg_rvalid === 1'b1) begin
            d = reg_rdata;
            ok = 1'b1;
         end else begin
            @(posedge clk);
            #1;
         end
      end
   endtask
endmodule // dtfs_host
`default_nettype wire

// [tb/testbench.sv]
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; $display("Error %0t: %h not %h", $time, g, e); end end
module testbench;
   import dtfs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [63:0] POS_MAP = 64'hB73ECDA98654210F; // code to row/col
   localparam logic [63:0] CODE_MAP = 64'h0CABF9876E54D321; // row/col to code
   logic CORE_CLK = 1'b0, SRST = 1'b1, HALF_DUPLEX = 1'b1, TONE_DET = 1'b0, VOICE_VALID = 1'b0;
   logic ENC_READY = 1'b0, DEC_VALID = 1'b0, DEC_IS_TONE = 1'b0, stall = 1'b1, ok;
   logic [1:0] TONE_ROW = 2'h0, TONE_COL = 2'h0;
   logic [FRAME_W-1:0] VOICE_DATA = '0, DEC_DATA = '0;
   wire logic REG_WR, REG_RD, REG_RVALID, VOICE_READY, ENC_VALID, ENC_IS_TONE, DEC_VOICE_VALID;
   wire logic TONE_GEN_EN, AUDIO_SILENCE;
   wire logic [1:0] TONE_GEN_ROW, TONE_GEN_COL;
   wire logic [7:0] REG_ADDR;
   wire logic [15:0] REG_WDATA, REG_RDATA;
   wire logic [FRAME_W-1:0] ENC_DATA, DEC_VOICE_DATA;
   int seed = 74469, err_total = 0, checked = 0;
   logic [31:0] rv, rr; // random words
   logic [15:0] ctrl = 16'h0000, rdat; // control shadow, read data
   logic fmt = 1'b0; // format shadow
   logic [3:0] cnt = 4'h0, code = 4'h0, rx = 4'h0; // send count, host code, received code
   logic [56:0] expq[$], exp_f; // expected output frames
   dtfs_top #(.FRAME_BITS(FRAME_W), .BUF_DEPTH(FIFO_DEPTH)) DUT (.CORE_CLK, .SRST, .HALF_DUPLEX, .REG_WR,
      .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA, .REG_RVALID, .TONE_DET, .TONE_ROW, .TONE_COL, .VOICE_VALID,
      .VOICE_READY, .VOICE_DATA, .ENC_VALID, .ENC_READY, .ENC_IS_TONE, .ENC_DATA, .DEC_VALID, .DEC_IS_TONE,
      .DEC_DATA, .DEC_VOICE_VALID, .DEC_VOICE_DATA, .TONE_GEN_EN, .TONE_GEN_ROW, .TONE_GEN_COL, .AUDIO_SILENCE);
   dtfs_host host (.clk(CORE_CLK), .reg_wr(REG_WR), .reg_rd(REG_RD), .reg_addr(REG_ADDR),
      .reg_wdata(REG_WDATA), .reg_rdata(REG_RDATA), .reg_rvalid(REG_RVALID));
   // 250 MHz clock
   initial forever #2 CORE_CLK = ~CORE_CLK;
   task automatic tick();
      @(posedge CORE_CLK);
      #1;
   endtask
   task automatic print_verdict();
      if (err_total == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // expected output frame for the frame now offered
   function automatic logic [56:0] enc_exp();
      if (HALF_DUPLEX && cnt != 4'h0) return {1'b1, 52'h0, code};
      if (HALF_DUPLEX && ctrl[11] && TONE_DET)
         return {1'b1, 52'h0, fmt ? {TONE_ROW, TONE_COL} : CODE_MAP[{TONE_ROW, TONE_COL, 2'b00} +: 4]};
      return {1'b0, VOICE_DATA};
   endfunction
   // offer one voice frame with random detector state
   task automatic send();
      tick();
      rv = $random(seed);
      {TONE_COL, TONE_ROW, TONE_DET} = rv[4:0];
      VOICE_DATA = {rv[23:0], rv};
      VOICE_VALID = 1'b1;
      for (int i = 0; i < 100 && VOICE_READY !== 1'b1; i++) tick();
      if (VOICE_READY !== 1'b1) begin
         err_total++;
         print_verdict();
      end
      expq.push_back(enc_exp());
      if (HALF_DUPLEX && cnt != 4'h0 && cnt != 4'hF) cnt--;
      tick();
      VOICE_VALID = 1'b0;
   endtask
   // one received frame, then the code register
   task automatic dec();
      logic hit;
      rv = $random(seed);
      tick();
      DEC_VALID = 1'b1;
      DEC_IS_TONE = rv[5];
      DEC_DATA = {rv[23:0], rv};
      hit = rv[5] && HALF_DUPLEX && ctrl[5];
      tick();
      if (hit) rx = rv[3:0];
      `CHK(TONE_GEN_EN, hit && ctrl[6])
      `CHK(AUDIO_SILENCE, hit && !ctrl[6])
      `CHK(DEC_VOICE_VALID, !hit)
      if (!hit) `CHK(DEC_VOICE_DATA, DEC_DATA)
      if (hit && ctrl[6]) `CHK({TONE_GEN_ROW, TONE_GEN_COL}, fmt ? rv[3:0] : POS_MAP[{rv[3:0], 2'b00} +: 4])
      DEC_VALID = 1'b0;
      DEC_DATA = ~DEC_DATA;
      host.rd(ADDR_RX_CODE, rdat, ok);
      `CHK({ok, rdat}, {5'h10, 8'h00, rx})
   endtask
   // random settings, then a read of a random place
   task automatic setregs();
      rv = $random(seed);
      fmt = rv[7];
      ctrl = {4'h0, rv[11], 4'h0, rv[6:5], 5'h00};
      {cnt, code} = rv[23:16];
      HALF_DUPLEX = rv[30] | rv[31];
      host.wr(ADDR_CODER_CFG, {8'h00, rv[7:0]});
      host.wr(ADDR_CODER_CTRL, ctrl);
      host.wr(ADDR_TONE_SEND, {8'h00, rv[23:16]});
      host.rd(rv[31:24], rdat, ok);
      `CHK({ok, rdat}, {1'b1, rv[31:24] == ADDR_RX_CODE ? {12'h000, rx} : 16'h0000})
   endtask
   // sink with random stalls
   initial forever begin
      tick();
      rr = $random(seed);
      ENC_READY = !stall && rr[1:0] != 2'b00;
   end
   // output frames against expectation, looked at mid cycle while they stand
   always @(negedge CORE_CLK) begin
      if (ENC_VALID === 1'b1 && ENC_READY === 1'b1) begin
         exp_f = expq.pop_front();
         `CHK({ENC_IS_TONE, ENC_DATA}, exp_f)
      end
   end
   // hang guard
   initial begin
      repeat (90000) @(posedge CORE_CLK);
      err_total++;
      print_verdict();
   end
   // main sequence
   initial begin
      repeat (4) tick();
      SRST = 1'b0;
      host.wr(ADDR_TONE_SEND, 16'h00F9);
      {cnt, code} = 8'hF9;
      repeat (FIFO_DEPTH) send();
      `CHK(VOICE_READY, 1'b0)
      stall = 1'b0;
      for (int n = 0; n < 80; n++) begin
         setregs();
         repeat (3) send();
         repeat (2) dec();
      end
      for (int i = 0; i < 300 && expq.size() > 0; i++) tick();
      `CHK(expq.size(), 0)
      SRST = 1'b1;
      repeat (4) tick();
      SRST = 1'b0;
      rx = 4'h0;
      host.rd(ADDR_RX_CODE, rdat, ok);
      `CHK({ok, rdat}, {1'b1, 16'h0000})
      print_verdict();
   end
endmodule // testbench
bind dtfs_top dtfs_chk #(.FRAME_BITS(FRAME_BITS)) u_chk (.CORE_CLK, .SRST, .HALF_DUPLEX, .REG_WR, .REG_RD,
   .REG_ADDR, .REG_WDATA, .REG_RDATA, .REG_RVALID, .VOICE_VALID, .VOICE_READY, .ENC_VALID, .ENC_READY,
   .ENC_IS_TONE, .ENC_DATA, .DEC_VALID, .DEC_IS_TONE, .DEC_DATA, .DEC_VOICE_VALID, .TONE_GEN_EN,
   .TONE_GEN_ROW, .TONE_GEN_COL, .AUDIO_SILENCE);
`default_nettype wire
